// ==== verilog/arx_map.vh ====
`ifndef ARX_MAP_VH
`define ARX_MAP_VH

// ============================================================
// Register offsets (3-bit register address)
`define ARX_OFF_RCV_STAT    3'h0
`define ARX_OFF_RCV_DATA    3'h1
`define ARX_OFF_BAUD_CTL    3'h2
`define ARX_OFF_DIV_LO      3'h3
`define ARX_OFF_DIV_HI      3'h4
`define ARX_OFF_TX_STAT     3'h5
`define ARX_OFF_IRQ_CTL     3'h6

// ============================================================
// receive_status_control fields
`define ARX_RS_PORT_EN      7
`define ARX_RS_NINE_SEL     6
`define ARX_RS_SINGLE       5
`define ARX_RS_CONT_EN      4
`define ARX_RS_ADDR_DET     3
`define ARX_RS_FRAME_ERR    2
`define ARX_RS_OVERRUN      1
`define ARX_RS_NINTH        0

// ============================================================
// baud_control and transmit_status_control fields
`define ARX_BC_IDLE         6
`define ARX_BC_WIDE         3
`define ARX_TS_SYNC         4
`define ARX_TS_HIGH         2
`define ARX_TS_EMPTY        1

// ============================================================
// Own receive interrupt register fields
`define ARX_IC_IRQ_EN       0
`define ARX_IC_PEND         1

// ============================================================
// Reset values
`define ARX_RST_CTL         5'h00
`define ARX_RST_BYTE        8'h00
`define ARX_RST_LINE        1'b1

// ============================================================
// Oversampling timing (sixteen ticks per bit)
`define ARX_OVS_LAST        4'hf
`define ARX_OVS_VOTE        4'h9
`define ARX_SLOW_PRE_LAST   2'h3
`define ARX_LAST_BIT8       4'h7
`define ARX_LAST_BIT9       4'h8

`endif

// ==== verilog/arx_sync.v ====
`timescale 1ns/1ps
`include "arx_map.vh"

// ============================================================
// Two-stage synchroniser for the serial input pin
module arx_sync (
	// Clock and reset
	input  wire core_clk_in,
	input  wire arst_n_in,
	// Asynchronous level in, synchronised level out
	input  wire async_in,
	output wire sync_out
);
	reg stage1;
	reg stage2;

	// Idle line is high, so both stages reset high
	always @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			stage1 <= `ARX_RST_LINE;
			stage2 <= `ARX_RST_LINE;
		end else begin
			stage1 <= async_in;
			stage2 <= stage1;
		end
	end

	assign sync_out = stage2;
endmodule // arx_sync

// ==== verilog/arx_queue.v ====
`timescale 1ns/1ps

// ============================================================
// Two-entry receive queue, each entry data plus tags
module arx_queue (
	// Clock and reset
	input  wire        core_clk_in,
	input  wire        arst_n_in,
	// Synchronous flush
	input  wire        clear_in,
	// Write side
	input  wire        push_in,
	input  wire [9:0]  push_data_in,
	// Read side
	input  wire        pop_in,
	output wire [9:0]  head_out,
	output wire        empty_out,
	output wire        full_out
);
	reg [9:0] mem [0:1];
	reg       wr_ptr;
	reg       rd_ptr;
	reg [1:0] count;

	assign head_out  = mem[rd_ptr];
	assign empty_out = (count == 2'h0);
	assign full_out  = (count == 2'h2);

	// Storage has no reset; pointers guard every read
	always @(posedge core_clk_in) begin
		if (push_in && !full_out) begin
			mem[wr_ptr] <= push_data_in;
		end
	end

	// Pointers and occupancy
	always @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			wr_ptr <= 1'b0;
			rd_ptr <= 1'b0;
			count  <= 2'h0;
		end else if (clear_in) begin
			wr_ptr <= 1'b0;
			rd_ptr <= 1'b0;
			count  <= 2'h0;
		end else begin
			if (push_in && !full_out) begin
				wr_ptr <= ~wr_ptr;
			end
			if (pop_in && !empty_out) begin
				rd_ptr <= ~rd_ptr;
			end
			case ({push_in && !full_out, pop_in && !empty_out})
				2'b10: count <= count + 2'h1;
				2'b01: count <= count - 2'h1;
				default: count <= count;
			endcase
		end
	end
endmodule // arx_queue

// ==== verilog/arx_top.v ====
// Behaviour
// - every queued character keeps its own framing-error tag.
// - frame_error_flag shows oldest unread tag; software cannot write it.
// - reception continues after framing errors; no clearing needed.
// - reading received data pops the queue, exposing next character and tag.
// - serial port disable resets receiver, clears frame flag; receive disable keeps it.
// - a framing error alone raises no interrupt request.
// - queue holds two; third complete character while full sets overrun_flag, or is dropped unflagged if a data read pops that cycle.
// - during overrun queued characters stay readable; new ones are dropped.
// - clearing receive or port enable clears overrun; software must do so.
// - nine-bit select shifts nine data bits per character.
// - received_ninth_bit shows ninth bit of oldest unread character.
// - address detect with nine bits queues only ninth-bit-one characters.
// - in nine-bit address detect mode every queued character reads ninth bit one.
// - pending flag sets on queue load; request needs receive_irq_enable.
// - start on falling edge, recheck low mid-bit, abandon silently if high.
// - sixteen-times oversampling with majority vote at bit centre.
// - stop sample zero tags framing error, otherwise tag cleared.
// - pending flag set while receiver enabled and queue not empty.
//
// Implementation choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`include "arx_map.vh"

module arx_top (
	// Clock and reset
	input  wire        core_clk_in,
	input  wire        arst_n_in,
	// Register port
	input  wire [2:0]  reg_addr_in,
	input  wire [7:0]  reg_wdata_in,
	input  wire        reg_wr_in,
	input  wire        reg_rd_in,
	output reg  [7:0]  reg_rdata_out,
	// Serial line
	input  wire        serial_in_pin_in,
	// Status towards the interrupt controller
	output wire        receive_pending_flag_out,
	output wire        rx_irq_req_out
);
	// ============================================================
	// Helpers
	localparam ST_IDLE  = 2'd0;
	localparam ST_START = 2'd1;
	localparam ST_DATA  = 2'd2;
	localparam ST_STOP  = 2'd3;

	// Address match, used for both write and read decode
	function reg_hit;
		input [2:0] addr;
		input [2:0] offset;
		begin
			reg_hit = (addr == offset);
		end
	endfunction

	// Two out of three majority
	function maj3;
		input [2:0] s;
		begin
			maj3 = (s[0] & s[1]) | (s[1] & s[2]) | (s[0] & s[2]);
		end
	endfunction

	// ============================================================
	// Declarations
	reg  [4:0]  rcv_ctl;          // serial_port_enable .. address_detect_enable
	reg  [7:0]  baud_divisor_low;
	reg  [7:0]  baud_divisor_high;
	reg         wide_baud_counter_select;
	reg         sync_mode;
	reg         high_speed_baud_select;
	reg         receive_irq_enable;
	reg         overrun_flag;
	reg  [1:0]  state;
	reg  [3:0]  os_cnt;
	reg  [3:0]  bit_idx;
	reg  [8:0]  receive_shift_reg;
	reg  [1:0]  votes;
	reg         line_prev;
	reg         char_done;
	reg         char_frame_error_flag;
	reg  [15:0] baud_cnt;
	reg  [1:0]  pre_cnt;
	wire        serial_port_enable;
	wire        nine_bit_receive_select;
	wire        continuous_receive_enable;
	wire        address_detect_enable;
	wire        rx_active;
	wire        line;
	wire [2:0]  vote_in;
	wire        vote;
	wire [15:0] divisor;
	wire        slow_mode;
	wire        div_wrap;
	wire        os_tick;
	wire [3:0]  last_bit;
	wire        char_ninth;
	wire [7:0]  char_data;
	wire        accept;
	wire        push;
	wire        pop;
	wire [9:0]  head;
	wire        q_empty;
	wire        q_full;
	wire        frame_error_flag;
	wire        received_ninth_bit;
	wire [7:0]  received_data_reg;

	assign serial_port_enable        = rcv_ctl[4];
	assign nine_bit_receive_select   = rcv_ctl[3];
	assign continuous_receive_enable = rcv_ctl[1];
	assign address_detect_enable     = rcv_ctl[0];

	// Receiver runs only in asynchronous mode with both enables set
	assign rx_active = serial_port_enable & continuous_receive_enable & ~sync_mode;

	// ============================================================
	// Pin synchroniser
	arx_sync u_sync (
		.core_clk_in (core_clk_in),
		.arst_n_in   (arst_n_in),
		.async_in    (serial_in_pin_in),
		.sync_out    (line)
	);

	// ============================================================
	// Oversampling tick generator
	// Low-speed eight-bit mode adds a divide by four so one tick is
	// still one sixteenth of a bit; the other modes tick every period.
	assign divisor   = wide_baud_counter_select ? {baud_divisor_high, baud_divisor_low}
	                                            : {8'h00, baud_divisor_low};
	assign slow_mode = ~high_speed_baud_select & ~wide_baud_counter_select;
	assign div_wrap  = (baud_cnt >= divisor);
	assign os_tick   = div_wrap & (~slow_mode | (pre_cnt == `ARX_SLOW_PRE_LAST));

	// Timer restarts on each start edge so the centre is well placed
	always @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			baud_cnt <= 16'h0000;
			pre_cnt  <= 2'h0;
		end else if (!rx_active || (state == ST_IDLE)) begin
			baud_cnt <= 16'h0000;
			pre_cnt  <= 2'h0;
		end else if (div_wrap) begin
			baud_cnt <= 16'h0000;
			pre_cnt  <= pre_cnt + 2'h1;
		end else begin
			baud_cnt <= baud_cnt + 16'h0001;
		end
	end

	// ============================================================
	// Bit recovery
	// Samples at ticks 7, 8 and 9 are voted at tick 9 (bit centre)
	assign vote_in  = {votes, line};
	assign vote     = maj3(vote_in);
	assign last_bit = nine_bit_receive_select ? `ARX_LAST_BIT9 : `ARX_LAST_BIT8;

	// Character state machine; port or receive disable parks it idle
	always @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state             <= ST_IDLE;
			os_cnt            <= 4'h0;
			bit_idx           <= 4'h0;
			receive_shift_reg <= 9'h000;
			votes             <= 2'h3;
			line_prev         <= `ARX_RST_LINE;
			char_done         <= 1'b0;
			char_frame_error_flag         <= 1'b0;
		end else if (!rx_active) begin
			state     <= ST_IDLE;
			os_cnt    <= 4'h0;
			bit_idx   <= 4'h0;
			line_prev <= `ARX_RST_LINE;
			char_done <= 1'b0;
		end else begin
			line_prev <= line;
			char_done <= 1'b0;
			if (os_tick) begin
				votes <= {votes[0], line};
			end
			case (state)
				ST_IDLE: begin
					if (line_prev && !line) begin
						state  <= ST_START;
						os_cnt <= 4'h0;
					end
				end
				ST_START: begin
					if (os_tick) begin
						os_cnt <= os_cnt + 4'h1;
						if ((os_cnt == `ARX_OVS_VOTE) && vote) begin
							state <= ST_IDLE;
						end else if (os_cnt == `ARX_OVS_LAST) begin
							state   <= ST_DATA;
							bit_idx <= 4'h0;
						end
					end
				end
				ST_DATA: begin
					if (os_tick) begin
						os_cnt <= os_cnt + 4'h1;
						if (os_cnt == `ARX_OVS_VOTE) begin
							receive_shift_reg <= {vote, receive_shift_reg[8:1]};
						end
						if (os_cnt == `ARX_OVS_LAST) begin
							if (bit_idx == last_bit) begin
								state <= ST_STOP;
							end else begin
								bit_idx <= bit_idx + 4'h1;
							end
						end
					end
				end
				ST_STOP: begin
					// Finish at the stop centre so the next edge is not missed
					if (os_tick) begin
						os_cnt <= os_cnt + 4'h1;
						if (os_cnt == `ARX_OVS_VOTE) begin
							char_done <= 1'b1;
							char_frame_error_flag <= ~vote;
							state     <= ST_IDLE;
						end
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// ============================================================
	// Character delivery
	// Eight-bit data sits in the upper shift bits after eight shifts
	assign char_ninth = nine_bit_receive_select & receive_shift_reg[8];
	assign char_data  = nine_bit_receive_select ? receive_shift_reg[7:0]
	                                            : receive_shift_reg[8:1];

	// Address filter only acts with nine-bit reception selected
	assign accept = char_done & (~address_detect_enable | ~nine_bit_receive_select
	                | char_ninth);
	assign push   = accept & ~overrun_flag & ~q_full;
	assign pop    = reg_rd_in & reg_hit(reg_addr_in, `ARX_OFF_RCV_DATA) & ~q_empty;

	// Queue entry: {framing tag, ninth bit, data}
	arx_queue u_queue (
		.core_clk_in  (core_clk_in),
		.arst_n_in    (arst_n_in),
		.clear_in     (~serial_port_enable),
		.push_in      (push),
		.push_data_in ({char_frame_error_flag, char_ninth, char_data}),
		.pop_in       (pop),
		.head_out     (head),
		.empty_out    (q_empty),
		.full_out     (q_full)
	);

	// Head of queue tags; an empty queue shows zeros
	assign frame_error_flag   = ~q_empty & head[9];
	assign received_ninth_bit = ~q_empty & head[8];
	assign received_data_reg  = head[7:0];

	// Overrun: set by a third complete character unless a data read pops that cycle, cleared by either enable
	always @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			overrun_flag <= 1'b0;
		end else if (!serial_port_enable || !continuous_receive_enable) begin
			overrun_flag <= 1'b0;
		end else if (accept && q_full && !pop) begin
			overrun_flag <= 1'b1;
		end
	end

	// Pending level; a framing tag never adds to the request
	assign receive_pending_flag_out = serial_port_enable & continuous_receive_enable
	                                  & ~q_empty;
	assign rx_irq_req_out = receive_pending_flag_out & receive_irq_enable;

	// ============================================================
	// Register writes
	// Status bits are not stored here, so writes cannot touch them
	always @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rcv_ctl                  <= `ARX_RST_CTL;
			baud_divisor_low         <= `ARX_RST_BYTE;
			baud_divisor_high        <= `ARX_RST_BYTE;
			wide_baud_counter_select <= 1'b0;
			sync_mode                <= 1'b0;
			high_speed_baud_select   <= 1'b0;
			receive_irq_enable       <= 1'b0;
		end else if (reg_wr_in) begin
			if (reg_hit(reg_addr_in, `ARX_OFF_RCV_STAT)) begin
				rcv_ctl <= reg_wdata_in[`ARX_RS_PORT_EN:`ARX_RS_ADDR_DET];
			end
			if (reg_hit(reg_addr_in, `ARX_OFF_DIV_LO)) begin
				baud_divisor_low <= reg_wdata_in;
			end
			if (reg_hit(reg_addr_in, `ARX_OFF_DIV_HI)) begin
				baud_divisor_high <= reg_wdata_in;
			end
			if (reg_hit(reg_addr_in, `ARX_OFF_BAUD_CTL)) begin
				wide_baud_counter_select <= reg_wdata_in[`ARX_BC_WIDE];
			end
			if (reg_hit(reg_addr_in, `ARX_OFF_TX_STAT)) begin
				sync_mode              <= reg_wdata_in[`ARX_TS_SYNC];
				high_speed_baud_select <= reg_wdata_in[`ARX_TS_HIGH];
			end
			if (reg_hit(reg_addr_in, `ARX_OFF_IRQ_CTL)) begin
				receive_irq_enable <= reg_wdata_in[`ARX_IC_IRQ_EN];
			end
		end
	end

	// ============================================================
	// Register reads, answered one cycle after the strobe
	// Unmapped offsets and cycles without a read return zero
	always @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			reg_rdata_out <= 8'h00;
		end else if (reg_rd_in) begin
			case (reg_addr_in)
				`ARX_OFF_RCV_STAT: reg_rdata_out <= {rcv_ctl, frame_error_flag,
				                                     overrun_flag, received_ninth_bit};
				`ARX_OFF_RCV_DATA: reg_rdata_out <= q_empty ? 8'h00 : received_data_reg;
				`ARX_OFF_BAUD_CTL: reg_rdata_out <= {1'b0, (state == ST_IDLE), 2'h0,
				                                     wide_baud_counter_select, 3'h0};
				`ARX_OFF_DIV_LO:   reg_rdata_out <= baud_divisor_low;
				`ARX_OFF_DIV_HI:   reg_rdata_out <= baud_divisor_high;
				`ARX_OFF_TX_STAT:  reg_rdata_out <= {3'h0, sync_mode, 1'b0,
				                                     high_speed_baud_select, 1'b1, 1'b0};
				`ARX_OFF_IRQ_CTL:  reg_rdata_out <= {6'h00, receive_pending_flag_out,
				                                     receive_irq_enable};
				default:           reg_rdata_out <= 8'h00;
			endcase
		end else begin
			reg_rdata_out <= 8'h00;
		end
	end
endmodule // arx_top

// ==== verif/arx_top_properties.sv ====
`timescale 1ns/1ps
`include "arx_map.vh"

// ============================================================
// Port-level checks on the receive status block
module arx_top_props (
	// Clock and reset
	input wire logic       core_clk_in,
	input wire logic       arst_n_in,
	// Register port
	input wire logic [2:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic       reg_wr_in,
	input wire logic       reg_rd_in,
	input wire logic [7:0] reg_rdata_out,
	// Serial line and status
	input wire logic       serial_in_pin_in,
	input wire logic       receive_pending_flag_out,
	input wire logic       rx_irq_req_out
);
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!arst_n_in);

	// Request never stands without a pending character
	property p_irq_needs_pending;
		rx_irq_req_out |-> receive_pending_flag_out;
	endproperty
	a_irq_needs_pending: assert property (p_irq_needs_pending)
		else $error("request raised with nothing pending");

	// Request rises only with a new character or an enable write
	property p_irq_rise_cause;
		$rose(rx_irq_req_out) |->
			$rose(receive_pending_flag_out) || $past(reg_wr_in && reg_addr_in == `ARX_OFF_IRQ_CTL);
	endproperty
	a_irq_rise_cause: assert property (p_irq_rise_cause)
		else $error("request rose without cause");

	// Queue content survives quiet cycles, overrun included
	property p_pending_hold;
		receive_pending_flag_out && !reg_rd_in && !reg_wr_in |=> receive_pending_flag_out;
	endproperty
	a_pending_hold: assert property (p_pending_hold)
		else $error("pending dropped without access");

	// Only a data read or a control write empties the view
	property p_pending_fall_cause;
		$fell(receive_pending_flag_out) |->
			$past(reg_wr_in) || $past(reg_rd_in && reg_addr_in == `ARX_OFF_RCV_DATA);
	endproperty
	a_pending_fall_cause: assert property (p_pending_fall_cause)
		else $error("pending fell without a pop");

	// Read data only in the cycle after a read
	property p_rdata_idle;
		!reg_rd_in |=> reg_rdata_out == 8'h00;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle)
		else $error("read data outside its cycle");

	// Interrupt register mirrors pending and request
	property p_irq_reg_mirror;
		reg_rd_in && reg_addr_in == `ARX_OFF_IRQ_CTL |=>
			reg_rdata_out[1] == $past(receive_pending_flag_out) &&
			(reg_rdata_out[0] & reg_rdata_out[1]) == $past(rx_irq_req_out);
	endproperty
	a_irq_reg_mirror: assert property (p_irq_reg_mirror)
		else $error("interrupt register disagrees with outputs");

	// Status read must not pop, so its flags can be taken first
	property p_status_read_keeps;
		receive_pending_flag_out && reg_rd_in && reg_addr_in == `ARX_OFF_RCV_STAT
			|=> receive_pending_flag_out;
	endproperty
	a_status_read_keeps: assert property (p_status_read_keeps)
		else $error("status read removed a character");

	// Dropping either enable hides the queue at once
	property p_disable_drops_pending;
		reg_wr_in && reg_addr_in == `ARX_OFF_RCV_STAT && !(reg_wdata_in[7] && reg_wdata_in[4])
			|=> !receive_pending_flag_out;
	endproperty
	a_disable_drops_pending: assert property (p_disable_drops_pending)
		else $error("pending survived a disable");
endmodule // arx_top_props

// ==== verif/arx_line_model.sv ====
`timescale 1ns/1ps

// ============================================================
// Remote transmitter on the shared receive line
module arx_line_model #(
	parameter BIT_CYC = 16
) (
	// Clock
	input  wire logic core_clk_in,
	// Line towards the receiver
	output logic      serial_out
);
	// Idle high, as pulled up between frames
	initial serial_out = 1'b1;

	// Bit length in clocks; a test may change it between frames
	integer bit_cyc;
	initial bit_cyc = BIT_CYC;

	// Start, data LSB first, stop, then a full idle bit so the next start is an edge
	task automatic send(input logic [8:0] d, input logic nine, input logic stop_ok);
		integer i;
		@(posedge core_clk_in);
		serial_out <= 1'b0;
		repeat (bit_cyc) @(posedge core_clk_in);
		for (i = 0; i < (nine ? 9 : 8); i = i + 1) begin
			serial_out <= d[i];
			repeat (bit_cyc) @(posedge core_clk_in);
		end
		serial_out <= stop_ok; // Low stop only when a test asks for it
		repeat (bit_cyc) @(posedge core_clk_in);
		serial_out <= 1'b1;
		repeat (bit_cyc) @(posedge core_clk_in);
	endtask

	// Short low pulse, gone before the start centre
	task automatic glitch(input integer n);
		@(posedge core_clk_in);
		serial_out <= 1'b0;
		repeat (n) @(posedge core_clk_in);
		serial_out <= 1'b1;
		repeat (2 * bit_cyc) @(posedge core_clk_in);
	endtask
endmodule // arx_line_model

// ==== verif/arx_top_bench.sv ====
`timescale 1ns/1ps
`include "arx_map.vh"
`define ARX_CHK(got, want) begin \
	cmp_count = cmp_count + 1; \
	if ((got) !== (want)) begin \
		fail_count = fail_count + 1; \
		$display("ERROR at %0t ns: got %h expected %h", $time, (got), (want)); \
	end \
end

// ============================================================
// Register-level bench for the receive status block
module arx_top_bench;
	logic       core_clk_in;
	logic       arst_n_in;
	logic [2:0] reg_addr_in;
	logic [7:0] reg_wdata_in;
	logic       reg_wr_in;
	logic       reg_rd_in;
	wire  [7:0] reg_rdata_out;
	wire        serial_line;
	wire        receive_pending_flag_out;
	wire        rx_irq_req_out;
	integer     fail_count;
	integer     cmp_count;

	arx_top u_dut (
		.core_clk_in              (core_clk_in),
		.arst_n_in                (arst_n_in),
		.reg_addr_in              (reg_addr_in),
		.reg_wdata_in             (reg_wdata_in),
		.reg_wr_in                (reg_wr_in),
		.reg_rd_in                (reg_rd_in),
		.reg_rdata_out            (reg_rdata_out),
		.serial_in_pin_in         (serial_line),
		.receive_pending_flag_out (receive_pending_flag_out),
		.rx_irq_req_out           (rx_irq_req_out)
	);

	// Divisor 0 with high speed gives sixteen cycles a bit
	arx_line_model #(.BIT_CYC(16)) u_line (
		.core_clk_in (core_clk_in),
		.serial_out  (serial_line)
	);

	// ============================================================
	// Clock and bus tasks
	initial begin
		core_clk_in = 1'b0;
		forever #4 core_clk_in = ~core_clk_in;
	end

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge core_clk_in);
		reg_addr_in  <= a;
		reg_wdata_in <= d;
		reg_wr_in    <= 1'b1;
		@(posedge core_clk_in);
		reg_wr_in    <= 1'b0;
	endtask

	// Data stand only in the cycle after the strobe
	task automatic rd_chk(input logic [2:0] a, input logic [7:0] want);
		@(posedge core_clk_in);
		reg_addr_in <= a;
		reg_rd_in   <= 1'b1;
		@(posedge core_clk_in);
		reg_rd_in   <= 1'b0;
		@(negedge core_clk_in);
		`ARX_CHK(reg_rdata_out, want)
	endtask

	task automatic wait_pend;
		integer n;
		n = 0;
		while (receive_pending_flag_out !== 1'b1 && n < 400) begin
			@(negedge core_clk_in);
			n = n + 1;
		end
		`ARX_CHK(receive_pending_flag_out, 1'b1)
		if (n >= 400) begin
			tally_and_finish;
		end
	endtask

	task automatic tally_and_finish;
		$display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// ============================================================
	// Main sequence
	initial begin
		arst_n_in    = 1'b0;
		reg_addr_in  = 3'h0;
		reg_wdata_in = 8'h00;
		reg_wr_in    = 1'b0;
		reg_rd_in    = 1'b0;
		fail_count   = 0;
		cmp_count    = 0;
		repeat (12) @(posedge core_clk_in);
		arst_n_in <= 1'b1;
		rd_chk(`ARX_OFF_RCV_STAT, 8'h00);
		rd_chk(`ARX_OFF_BAUD_CTL, 8'h40);
		rd_chk(`ARX_OFF_TX_STAT, 8'h02);
		rd_chk(`ARX_OFF_IRQ_CTL, 8'h00);
		rd_chk(3'h7, 8'h00);
		wr(`ARX_OFF_RCV_STAT, 8'h07);
		rd_chk(`ARX_OFF_RCV_STAT, 8'h00);
		$display("Test reset and access finished");
		// Setup order: baud, port, interrupts, receive last
		wr(`ARX_OFF_DIV_HI, 8'ha5);
		rd_chk(`ARX_OFF_DIV_HI, 8'ha5);
		wr(`ARX_OFF_DIV_HI, 8'h00);
		wr(`ARX_OFF_DIV_LO, 8'h00);
		wr(`ARX_OFF_TX_STAT, 8'h04);
		wr(`ARX_OFF_RCV_STAT, 8'h80);
		wr(`ARX_OFF_IRQ_CTL, 8'h01);
		wr(`ARX_OFF_RCV_STAT, 8'h90);
		u_line.send(9'h0a5, 1'b0, 1'b1);
		u_line.send(9'h03c, 1'b0, 1'b0);
		wait_pend;
		`ARX_CHK(rx_irq_req_out, 1'b1)
		rd_chk(`ARX_OFF_RCV_STAT, 8'h90);
		rd_chk(`ARX_OFF_RCV_DATA, 8'ha5);
		rd_chk(`ARX_OFF_RCV_STAT, 8'h94);
		rd_chk(`ARX_OFF_RCV_DATA, 8'h3c);
		rd_chk(`ARX_OFF_RCV_STAT, 8'h90);
		$display("Test framing tags finished");
		u_line.send(9'h011, 1'b0, 1'b1);
		u_line.send(9'h022, 1'b0, 1'b1);
		u_line.send(9'h033, 1'b0, 1'b1);
		rd_chk(`ARX_OFF_RCV_STAT, 8'h92);
		u_line.send(9'h044, 1'b0, 1'b1);
		rd_chk(`ARX_OFF_RCV_DATA, 8'h11);
		rd_chk(`ARX_OFF_RCV_DATA, 8'h22);
		rd_chk(`ARX_OFF_RCV_DATA, 8'h00);
		wr(`ARX_OFF_RCV_STAT, 8'h80);
		rd_chk(`ARX_OFF_RCV_STAT, 8'h80);
		wr(`ARX_OFF_RCV_STAT, 8'h90);
		u_line.send(9'h055, 1'b0, 1'b1);
		wait_pend;
		rd_chk(`ARX_OFF_RCV_DATA, 8'h55);
		$display("Test overrun finished");
		wr(`ARX_OFF_IRQ_CTL, 8'h00);
		u_line.send(9'h066, 1'b0, 1'b0);
		wait_pend;
		`ARX_CHK(rx_irq_req_out, 1'b0)
		rd_chk(`ARX_OFF_IRQ_CTL, 8'h02);
		wr(`ARX_OFF_RCV_STAT, 8'h80);
		rd_chk(`ARX_OFF_RCV_STAT, 8'h84);
		wr(`ARX_OFF_RCV_STAT, 8'h00);
		rd_chk(`ARX_OFF_RCV_STAT, 8'h00);
		wr(`ARX_OFF_RCV_STAT, 8'h90);
		rd_chk(`ARX_OFF_RCV_DATA, 8'h00);
		wr(`ARX_OFF_IRQ_CTL, 8'h01);
		$display("Test enables finished");
		wr(`ARX_OFF_RCV_STAT, 8'hd0);
		u_line.send(9'h1a5, 1'b1, 1'b1);
		u_line.send(9'h05a, 1'b1, 1'b1);
		wait_pend;
		rd_chk(`ARX_OFF_RCV_STAT, 8'hd1);
		rd_chk(`ARX_OFF_RCV_DATA, 8'ha5);
		rd_chk(`ARX_OFF_RCV_STAT, 8'hd0);
		rd_chk(`ARX_OFF_RCV_DATA, 8'h5a);
		$display("Test nine bit finished");
		wr(`ARX_OFF_RCV_STAT, 8'hd8);
		u_line.send(9'h012, 1'b1, 1'b1);
		u_line.send(9'h1c3, 1'b1, 1'b1);
		wait_pend;
		rd_chk(`ARX_OFF_RCV_STAT, 8'hd9);
		rd_chk(`ARX_OFF_RCV_DATA, 8'hc3);
		`ARX_CHK(receive_pending_flag_out, 1'b0)
		wr(`ARX_OFF_RCV_STAT, 8'hd0);
		u_line.send(9'h077, 1'b1, 1'b1);
		wait_pend;
		rd_chk(`ARX_OFF_RCV_STAT, 8'hd0);
		rd_chk(`ARX_OFF_RCV_DATA, 8'h77);
		$display("Test address detect finished");
		wr(`ARX_OFF_RCV_STAT, 8'h98);
		u_line.glitch(4);
		u_line.send(9'h081, 1'b0, 1'b1);
		wait_pend;
		rd_chk(`ARX_OFF_RCV_DATA, 8'h81);
		`ARX_CHK(receive_pending_flag_out, 1'b0)
		$display("Test start glitch finished");
		// Second overrun, recovered by port disable alone
		wr(`ARX_OFF_RCV_STAT, 8'h90);
		repeat (3) u_line.send(9'h099, 1'b0, 1'b1);
		rd_chk(`ARX_OFF_RCV_STAT, 8'h92);
		wr(`ARX_OFF_RCV_STAT, 8'h10);
		rd_chk(`ARX_OFF_RCV_STAT, 8'h10);
		wr(`ARX_OFF_RCV_STAT, 8'h90);
		// Low-speed eight-bit divide: four clocks a tick, 64 a bit
		wr(`ARX_OFF_TX_STAT, 8'h00);
		u_line.bit_cyc = 64;
		u_line.send(9'h0c6, 1'b0, 1'b1);
		wait_pend;
		rd_chk(`ARX_OFF_RCV_DATA, 8'hc6);
		// Wide counter cancels the divide by four
		wr(`ARX_OFF_BAUD_CTL, 8'h08);
		rd_chk(`ARX_OFF_BAUD_CTL, 8'h48);
		u_line.bit_cyc = 16;
		u_line.send(9'h039, 1'b0, 1'b1);
		wait_pend;
		rd_chk(`ARX_OFF_RCV_DATA, 8'h39);
		// Synchronous mode must park the receiver
		wr(`ARX_OFF_TX_STAT, 8'h10);
		u_line.send(9'h0f0, 1'b0, 1'b1);
		rd_chk(`ARX_OFF_RCV_STAT, 8'h90);
		`ARX_CHK(receive_pending_flag_out, 1'b0)
		$display("Test baud modes finished");
		tally_and_finish;
	end
endmodule // arx_top_bench

bind arx_top arx_top_props u_props (
	.core_clk_in              (core_clk_in),
	.arst_n_in                (arst_n_in),
	.reg_addr_in              (reg_addr_in),
	.reg_wdata_in             (reg_wdata_in),
	.reg_wr_in                (reg_wr_in),
	.reg_rd_in                (reg_rd_in),
	.reg_rdata_out            (reg_rdata_out),
	.serial_in_pin_in         (serial_in_pin_in),
	.receive_pending_flag_out (receive_pending_flag_out),
	.rx_irq_req_out           (rx_irq_req_out)
);
